//--- rtl/ccs_consts.svh
// Register offsets, field positions, reset values and timing counts of the clock switcher.
// Assumes a 100 MHz pclk and APB byte addressing.
`ifndef CCS_CONSTS_SVH
`define CCS_CONSTS_SVH

`define CCS_OFF_OSC_RUN      12'h000
`define CCS_OFF_SYS_SEL      12'h004
`define CCS_OFF_SUB_SEL      12'h008

`define CCS_BIT_HIGH_STOP    0
`define CCS_BIT_MID_EN       1
`define CCS_BIT_XT1_STOP     6
`define CCS_BIT_X1_STOP      7
`define CCS_BIT_MID_SEL      0
`define CCS_BIT_MID_FLAG     1
`define CCS_BIT_MAIN_SEL     4
`define CCS_BIT_MAIN_FLAG    5
`define CCS_BIT_SUB_SEL      6
`define CCS_BIT_SUB_FLAG     7
`define CCS_BIT_LOW_SRC      0

`define CCS_RST_OSC_RUN      8'hc0
`define CCS_RST_SYS_SEL      8'h00
`define CCS_RST_SUB_SEL      8'h00
`define CCS_OSC_RUN_WMASK    8'hc3
`define CCS_SYS_SEL_WMASK    8'h51

`define CCS_CLK_NS           10
`define CCS_MID_STAB_NS      4000
`define CCS_LOW_STAB_NS      210000
`define CCS_MID_STAB_CYC     (`CCS_MID_STAB_NS / `CCS_CLK_NS)
`define CCS_LOW_STAB_CYC     (`CCS_LOW_STAB_NS / `CCS_CLK_NS)

`endif

//--- rtl/ccs_pkg.sv
// Types shared by the clock switcher.
// Assumes nothing beyond the constants header.
`default_nettype none
package ccs_pkg;
    typedef enum logic [2:0] {
        CCS_SRC_HIGH = 3'b001,
        CCS_SRC_MID  = 3'b010,
        CCS_SRC_SUB  = 3'b100
    } ccs_src_t;
endpackage
`default_nettype wire

//--- rtl/ccs_clock_switch.sv
// Clock source switcher: oscillator run control, source select and status over APB.
// Assumes the middle and low oscillators are modelled by start-up counters on pclk; the high one has none.
//
// Contract
// - Mid oscillator enable bit starts middle oscillator
// - Mid select bit makes middle the main clock
// - Mid active flag reads 1 after switch
// - High stop bit stops high oscillator
// - Low source select starts low oscillator, routes it
// - Subsystem select bit routes subsystem to CPU
// - Subsystem active flag reads 1 after switch
//
// The address map and the APB interface to the registers were decided locally.
`include "ccs_consts.svh"
`default_nettype none
module ccs_clock_switch
    import ccs_pkg::*;
#(
    parameter int MID_STAB_CYC = `CCS_MID_STAB_CYC,
    parameter int LOW_STAB_CYC = `CCS_LOW_STAB_CYC
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             high_osc_run,
    output logic             mid_osc_run,
    output logic             low_osc_run,
    output ccs_src_t         clk_source
);
    logic [7:0]  oscillator_run_control;
    logic [7:0]  system_clock_select;
    logic [7:0]  subsystem_source_select;
    logic [17:0] mid_cnt;
    logic [17:0] low_cnt;
    ccs_src_t    src;
    logic [7:0]  next_osc_run;
    logic [7:0]  next_sys_sel;
    logic [7:0]  next_sub_sel;
    logic [17:0] next_mid_cnt;
    logic [17:0] next_low_cnt;
    ccs_src_t    next_src;
    logic [31:0] next_prdata;
    logic        wr;
    logic        rd;
    logic        mid_ready;
    logic        low_ready;
    logic        mapped;

    function automatic logic [17:0] stab_step(input logic run, input logic [17:0] cnt,
                                              input int lim);
        if (!run) begin
            stab_step = 18'h0;
        end else if (cnt < 18'(lim)) begin
            stab_step = cnt + 18'h1;
        end else begin
            stab_step = cnt;
        end
    endfunction

    // Single-cycle access phase; no wait states
    assign pready  = 1'b1;
    assign wr      = psel && penable && pwrite;
    assign rd      = psel && !penable && !pwrite;
    assign mapped  = (paddr == `CCS_OFF_OSC_RUN) || (paddr == `CCS_OFF_SYS_SEL)
                     || (paddr == `CCS_OFF_SUB_SEL);
    assign pslverr = psel && penable && !mapped;

    assign mid_osc_run  = oscillator_run_control[`CCS_BIT_MID_EN];
    assign high_osc_run = !oscillator_run_control[`CCS_BIT_HIGH_STOP];
    assign low_osc_run  = subsystem_source_select[`CCS_BIT_LOW_SRC];
    assign mid_ready    = (mid_cnt >= 18'(MID_STAB_CYC));
    assign low_ready    = (low_cnt >= 18'(LOW_STAB_CYC));
    assign clk_source   = src;

    always_comb begin
        next_osc_run = oscillator_run_control;
        next_sys_sel = system_clock_select;
        next_sub_sel = subsystem_source_select;
        next_prdata  = 32'h0;
        if (wr && paddr == `CCS_OFF_OSC_RUN) begin
            next_osc_run = pwdata[7:0] & `CCS_OSC_RUN_WMASK;
        end
        if (wr && paddr == `CCS_OFF_SYS_SEL) begin
            next_sys_sel = (system_clock_select & ~`CCS_SYS_SEL_WMASK)
                           | (pwdata[7:0] & `CCS_SYS_SEL_WMASK);
        end
        if (wr && paddr == `CCS_OFF_SUB_SEL) begin
            // Upper bits forced to zero
            next_sub_sel = {7'h0, pwdata[`CCS_BIT_LOW_SRC]};
        end
        // Mid and subsystem flags track the clock actually in use, not the request; the main flag always reads 0
        next_sys_sel[`CCS_BIT_MID_FLAG] = (next_src == CCS_SRC_MID);
        next_sys_sel[`CCS_BIT_SUB_FLAG] = (next_src == CCS_SRC_SUB);
        next_sys_sel[`CCS_BIT_MAIN_FLAG] = 1'b0;
        if (rd) begin
            unique case (paddr)
                `CCS_OFF_OSC_RUN: next_prdata = {24'h0, oscillator_run_control};
                `CCS_OFF_SYS_SEL: next_prdata = {24'h0, system_clock_select};
                `CCS_OFF_SUB_SEL: next_prdata = {24'h0, subsystem_source_select};
                default:          next_prdata = 32'h0;
            endcase
        end else begin
            next_prdata = prdata;
        end
    end

    // Switch only when the target is stable; a stopped target leaves the old clock in place
    always_comb begin
        next_mid_cnt = stab_step(mid_osc_run, mid_cnt, MID_STAB_CYC);
        next_low_cnt = stab_step(low_osc_run, low_cnt, LOW_STAB_CYC);
        next_src     = src;
        if (system_clock_select[`CCS_BIT_SUB_SEL]) begin
            if (low_ready) begin
                next_src = CCS_SRC_SUB;
            end
        end else if (system_clock_select[`CCS_BIT_MID_SEL]) begin
            if (mid_ready) begin
                next_src = CCS_SRC_MID;
            end
        end else if (high_osc_run) begin
            next_src = CCS_SRC_HIGH;
        end
    end

    // Register file and read data
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            oscillator_run_control  <= `CCS_RST_OSC_RUN;
            system_clock_select     <= `CCS_RST_SYS_SEL;
            subsystem_source_select <= `CCS_RST_SUB_SEL;
            prdata                  <= 32'h0;
        end else begin
            oscillator_run_control  <= next_osc_run;
            system_clock_select     <= next_sys_sel;
            subsystem_source_select <= next_sub_sel;
            prdata                  <= next_prdata;
        end
    end

    // Start-up counters and the source in use
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mid_cnt <= 18'h0;
            low_cnt <= 18'h0;
            src     <= CCS_SRC_HIGH;
        end else begin
            mid_cnt <= next_mid_cnt;
            low_cnt <= next_low_cnt;
            src     <= next_src;
        end
    end

    // Counter checks too, so a stuck count cannot hide behind a late switch
    a_mid_flag_src: assert property (@(posedge pclk) disable iff (!presetn)
        system_clock_select[`CCS_BIT_MID_FLAG] == (src == CCS_SRC_MID))
        else $error("mid flag disagrees with source");
    a_sub_flag_src: assert property (@(posedge pclk) disable iff (!presetn)
        system_clock_select[`CCS_BIT_SUB_FLAG] == (src == CCS_SRC_SUB))
        else $error("sub flag disagrees with source");
    a_mid_needs_stable: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(src == CCS_SRC_MID) |-> $past(mid_ready))
        else $error("middle taken before stable");
    a_sub_needs_stable: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(src == CCS_SRC_SUB) |-> $past(low_ready))
        else $error("subsystem taken before stable");
    a_mid_enable_write: assert property (@(posedge pclk) disable iff (!presetn)
        wr && paddr == `CCS_OFF_OSC_RUN |=> mid_osc_run == $past(pwdata[1]))
        else $error("mid enable not applied");
    a_high_stop_write: assert property (@(posedge pclk) disable iff (!presetn)
        wr && paddr == `CCS_OFF_OSC_RUN |=> high_osc_run == !$past(pwdata[0]))
        else $error("high stop not applied");
    a_low_select_write: assert property (@(posedge pclk) disable iff (!presetn)
        wr && paddr == `CCS_OFF_SUB_SEL |=> low_osc_run == $past(pwdata[0])
        && subsystem_source_select[7:1] == 7'h0)
        else $error("low select not applied");
    a_sel_write: assert property (@(posedge pclk) disable iff (!presetn)
        wr && paddr == `CCS_OFF_SYS_SEL
        |=> system_clock_select[`CCS_BIT_MID_SEL] == $past(pwdata[`CCS_BIT_MID_SEL])
        && system_clock_select[`CCS_BIT_SUB_SEL] == $past(pwdata[`CCS_BIT_SUB_SEL]))
        else $error("select write not applied");
    a_sys_read_data: assert property (@(posedge pclk) disable iff (!presetn)
        rd && paddr == `CCS_OFF_SYS_SEL
        |=> prdata == {24'h0, $past(system_clock_select)})
        else $error("select register read wrong");
    a_mid_switch_time: assert property (@(posedge pclk) disable iff (!presetn)
        system_clock_select[`CCS_BIT_MID_SEL] && !system_clock_select[`CCS_BIT_SUB_SEL]
        && mid_ready |=> src == CCS_SRC_MID)
        else $error("middle select not followed");
    a_sub_switch_time: assert property (@(posedge pclk) disable iff (!presetn)
        system_clock_select[`CCS_BIT_SUB_SEL] && low_ready |=> src == CCS_SRC_SUB)
        else $error("subsystem select not followed");
    a_high_return: assert property (@(posedge pclk) disable iff (!presetn)
        !system_clock_select[`CCS_BIT_SUB_SEL] && !system_clock_select[`CCS_BIT_MID_SEL]
        && high_osc_run |=> src == CCS_SRC_HIGH)
        else $error("high source not restored");
    a_mid_hold_unready: assert property (@(posedge pclk) disable iff (!presetn)
        system_clock_select[`CCS_BIT_MID_SEL] && !system_clock_select[`CCS_BIT_SUB_SEL]
        && !mid_ready |=> $stable(src))
        else $error("source moved before middle stable");
    a_sub_hold_unready: assert property (@(posedge pclk) disable iff (!presetn)
        system_clock_select[`CCS_BIT_SUB_SEL] && !low_ready |=> $stable(src))
        else $error("source moved before subsystem stable");
    a_mid_cnt_step: assert property (@(posedge pclk) disable iff (!presetn)
        mid_osc_run && !mid_ready |=> mid_cnt == $past(mid_cnt) + 18'h1)
        else $error("middle start-up count stalled");
    a_low_cnt_step: assert property (@(posedge pclk) disable iff (!presetn)
        low_osc_run && !low_ready |=> low_cnt == $past(low_cnt) + 18'h1)
        else $error("low start-up count stalled");
    a_mid_cnt_clear: assert property (@(posedge pclk) disable iff (!presetn)
        !mid_osc_run |=> mid_cnt == 18'h0)
        else $error("middle count kept while stopped");
    a_low_cnt_clear: assert property (@(posedge pclk) disable iff (!presetn)
        !low_osc_run |=> low_cnt == 18'h0)
        else $error("low count kept while stopped");
endmodule
`default_nettype wire

//--- testbench/ccs_clock_switch_tb.sv
// Self-checking bench for the clock source switcher, driven over APB.
// Assumes an APB slave that answers with pready and shortened start-up counts.
`include "ccs_consts.svh"
`default_nettype none
module ccs_clock_switch_tb
    import ccs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int MID_CYC = 4;
    localparam int LOW_CYC = 20;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        high_osc_run;
    logic        mid_osc_run;
    logic        low_osc_run;
    ccs_src_t    clk_source;
    logic [31:0] rd;
    logic        err;
    int          failures = 0;
    int          n_compared = 0;
    int          cycles = 0;
    ccs_clock_switch #(.MID_STAB_CYC(MID_CYC), .LOW_STAB_CYC(LOW_CYC)) DUT (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .high_osc_run(high_osc_run), .mid_osc_run(mid_osc_run),
        .low_osc_run(low_osc_run), .clk_source(clk_source));
    initial begin
        forever #5 pclk = ~pclk;
    end
    task automatic print_verdict();
        $display("Compared %0d, mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // Generous ceiling: the whole sequence needs well under a thousand cycles
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            failures++;
            print_verdict();
        end
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Outputs launched at the access edge settle before the caller looks
        @(negedge pclk);
    endtask
    // Poll the select register until the masked flag shows, bounded
    task automatic wait_flag(input logic [7:0] m);
        for (int i = 0; i < 40; i++) begin
            apb(1'b0, `CCS_OFF_SYS_SEL, 32'h0);
            if ((rd[7:0] & m) == m) break;
        end
    endtask
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        check({29'h0, clk_source}, {29'h0, CCS_SRC_HIGH});
        check({31'h0, high_osc_run}, 32'h1);
        apb(1'b0, `CCS_OFF_OSC_RUN, 32'h0);
        check(rd, 32'h000000c0);
        apb(1'b0, `CCS_OFF_SUB_SEL, 32'h0);
        check(rd, 32'h0);
        apb(1'b0, 12'h00c, 32'h0);
        check({rd[30:0], err}, 32'h1);
        // Select middle while its oscillator is stopped: old clock must stay
        apb(1'b1, `CCS_OFF_SYS_SEL, 32'h000000bf);
        repeat (MID_CYC + 4) @(posedge pclk);
        apb(1'b0, `CCS_OFF_SYS_SEL, 32'h0);
        check(rd, 32'h00000011);
        check({29'h0, clk_source}, {29'h0, CCS_SRC_HIGH});
        apb(1'b1, `CCS_OFF_SYS_SEL, 32'h00000000);
        apb(1'b1, `CCS_OFF_OSC_RUN, 32'h000000c2);
        check({31'h0, mid_osc_run}, 32'h1);
        repeat (MID_CYC) @(posedge pclk);
        apb(1'b1, `CCS_OFF_SYS_SEL, 32'h00000001);
        wait_flag(8'h02);
        check(rd, 32'h00000003);
        check({29'h0, clk_source}, {29'h0, CCS_SRC_MID});
        apb(1'b1, `CCS_OFF_OSC_RUN, 32'h000000c3);
        check({31'h0, high_osc_run}, 32'h0);
        apb(1'b1, `CCS_OFF_SUB_SEL, 32'h00000001);
        check({31'h0, low_osc_run}, 32'h1);
        // Deliberately selected before start-up ends: flag must still be clear
        apb(1'b1, `CCS_OFF_SYS_SEL, 32'h00000041);
        apb(1'b0, `CCS_OFF_SYS_SEL, 32'h0);
        check({30'h0, rd[7:6]}, 32'h1);
        wait_flag(8'h80);
        check({30'h0, rd[7:6]}, 32'h3);
        check({29'h0, clk_source}, {29'h0, CCS_SRC_SUB});
        // Low oscillator kept running: back to middle, then return with no wait
        apb(1'b1, `CCS_OFF_SYS_SEL, 32'h00000001);
        wait_flag(8'h02);
        check(rd, 32'h00000003);
        apb(1'b1, `CCS_OFF_SYS_SEL, 32'h00000041);
        wait_flag(8'h80);
        check(rd, 32'h000000c1);
        // Mid-run reset, then the low oscillator from cold with its full wait
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(negedge pclk);
        check({29'h0, clk_source}, {29'h0, CCS_SRC_HIGH});
        check({29'h0, high_osc_run, mid_osc_run, low_osc_run}, 32'h4);
        apb(1'b1, `CCS_OFF_SUB_SEL, 32'h000000ff);
        apb(1'b0, `CCS_OFF_SUB_SEL, 32'h0);
        check(rd, 32'h00000001);
        repeat (LOW_CYC) @(posedge pclk);
        apb(1'b1, `CCS_OFF_SYS_SEL, 32'h00000040);
        wait_flag(8'h80);
        check(rd, 32'h000000c0);
        print_verdict();
    end
endmodule
`default_nettype wire
